// File: verilog/lq_var_pkg.sv
/*
 Constants and types shared by the link quality and variance status bank.
 Assumes a single 200 MHz register clock and APB access with 32-bit data.
*/
// Overview of operation
// - The variance sum is valid for software only while the ready flag is set.
// - After freeze, the first data read gives sum bits 15:0, the next 31:16.
// - Bit 15 enables the monitor, which only acts while a 100Mb link is up.
// - A high threshold set to its maximum or a low threshold set to its minimum never flags a violation.
// - Any violation raises the interrupt when the interrupt enable is set.
// - Reading the monitor register clears the warning flags it returned and re-arms the interrupt.
// - Bit 9 flags frequency control high, bit 8 frequency control low.
// - Bit 7 flags frequency offset high, bit 6 frequency offset low.
// - Bit 5 flags baseline wander high, bit 4 baseline wander low.
// - Bit 3 flags gain control high, bit 2 gain control low.
// - Bit 1 flags equalizer coefficient high, bit 0 equalizer coefficient low.
// - Monitor register bits 14:10 ignore writes and read as zero.
// - An optional automatic 100Mb link reset follows the monitor status.
// - Ready clears itself after two consecutive variance data reads.
// - Freeze clears itself after two consecutive variance data reads.
// - Timer picks 2, 4, 6 or 8 units of 2^17 8ns cycles; writing restarts.
// - Variance computation runs only while enabled; enable is off after reset.
package lq_var_pkg;
   // -----------------------------------------------------------------
   // Register indices; the byte address is four times the index.
   // -----------------------------------------------------------------
   localparam logic [7:0] IDX_VAR_CTRL  = 8'h1A;
   localparam logic [7:0] IDX_SUM_WIN   = 8'h1B;
   localparam logic [7:0] IDX_LQ_MON    = 8'h1D;
   localparam logic [7:0] IDX_LQ_EXTRA  = 8'h1E;
   // Field positions.
   localparam int VAR_RDY_BIT    = 15;
   localparam int VAR_FREEZE_BIT = 3;
   localparam int VAR_TIMER_LSB  = 1;
   localparam int VAR_EN_BIT     = 0;
   localparam int LQ_ON_BIT      = 15;
   localparam int EXTRA_IRQ_BIT  = 0;
   localparam int EXTRA_ARST_BIT = 1;
   // Reset values.
   localparam logic [15:0] VAR_CTRL_RST = 16'h0000;
   localparam logic [15:0] LQ_MON_RST   = 16'h0000;
   localparam logic [1:0]  EXTRA_RST    = 2'h0;
   // Timing: one variance unit is 2^17 cycles of an 8 ns clock.
   localparam int CLK_PERIOD_NS = 5;
   localparam int VAR_UNIT_NS   = 1048576;
   localparam int VAR_UNIT_CYC  = VAR_UNIT_NS / CLK_PERIOD_NS;
   // Monitored parameters and their width.
   localparam int NUM_PARAM  = 5;
   localparam int PARAM_W    = 8;
   typedef logic [PARAM_W-1:0] param_t;
   typedef struct packed {
      param_t hi;
      param_t lo;
   } thr_pair_t;
   typedef enum logic {HALF_LOW = 1'b0, HALF_HIGH = 1'b1} half_t;
endpackage : lq_var_pkg

// File: verilog/lq_var_status.sv
/*
 APB register bank for the variance readout and the link quality monitor.
 Assumes thresholds, parameter values and variance samples come from the
 receiver datapath, already synchronous to pclk.
*/
`timescale 1ns/1ps
module lq_var_status
   import lq_var_pkg::*;
#(
   parameter int UNIT_CYC = VAR_UNIT_CYC
) (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [31:0]                  paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire logic                         link_100_up,
   input  wire param_t    [NUM_PARAM-1:0]    param_value,
   input  wire thr_pair_t [NUM_PARAM-1:0]    thr_value,
   input  wire logic                         var_sample_valid,
   input  wire logic signed [7:0]            var_sample,
   output logic                              lq_irq,
   output logic                              link_reset_req
);
   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   logic [29:0] idx;
   logic        setup_ph;
   logic        access_ph;
   logic        hit_ctrl;
   logic        hit_data;
   logic        hit_mon;
   logic        hit_extra;
   logic        mapped;
   logic        wr_ctrl;
   logic        rd_data;
   logic        rd_mon;

   // Word index from the byte address; access completes in one access cycle.
   assign idx       = paddr[31:2];
   assign setup_ph  = psel & ~penable;
   assign access_ph = psel & penable;
   assign hit_ctrl  = (idx == 30'(IDX_VAR_CTRL)) & (paddr[1:0] == 2'h0);
   assign hit_data  = (idx == 30'(IDX_SUM_WIN)) & (paddr[1:0] == 2'h0);
   assign hit_mon   = (idx == 30'(IDX_LQ_MON)) & (paddr[1:0] == 2'h0);
   assign hit_extra = (idx == 30'(IDX_LQ_EXTRA)) & (paddr[1:0] == 2'h0);
   assign mapped    = hit_ctrl | hit_data | hit_mon | hit_extra;
   assign pready    = penable;
   assign pslverr   = access_ph & ~mapped;
   assign wr_ctrl   = access_ph & pwrite & hit_ctrl;
   assign rd_data   = access_ph & ~pwrite & hit_data;
   assign rd_mon    = access_ph & ~pwrite & hit_mon;

   // -----------------------------------------------------------------
   // Link quality monitor
   // -----------------------------------------------------------------
   logic                   mon_on_reg;
   logic                   mon_on_next;
   logic [1:0]             extra_reg;
   logic [1:0]             extra_next;
   logic [2*NUM_PARAM-1:0] flags_reg;
   logic [2*NUM_PARAM-1:0] flags_next;
   logic [2*NUM_PARAM-1:0] viol;
   logic                   irq_reg;
   logic                   irq_next;
   logic                   armed_reg;
   logic                   armed_next;
   logic                   lrst_reg;
   logic                   lrst_next;
   logic                   mon_active;
   logic [31:0]            prdata_reg;
   logic [31:0]            prdata_next;

   // The monitor only acts on a live 100Mb link.
   assign mon_active = mon_on_reg & link_100_up;

   // Threshold compare per parameter; an all-ones high or all-zeros low threshold never fires.
   for (genvar g = 0; g < NUM_PARAM; g++) begin : g_cmp
      assign viol[2*g+1] = mon_active & (thr_value[g].hi != {PARAM_W{1'b1}})
                           & (param_value[g] > thr_value[g].hi);
      assign viol[2*g]   = mon_active & (thr_value[g].lo != {PARAM_W{1'b0}})
                           & (param_value[g] < thr_value[g].lo);
   end

   // Flags, interrupt and auto link reset next values.
   always_comb begin
      mon_on_next = mon_on_reg;
      extra_next  = extra_reg;
      flags_next  = flags_reg;
      irq_next    = irq_reg;
      armed_next  = armed_reg;
      lrst_next   = 1'b0;
      if (access_ph & pwrite & hit_mon) begin
         mon_on_next = pwdata[LQ_ON_BIT]; // Bits 14:10 are not stored.
      end
      if (access_ph & pwrite & hit_extra) begin
         extra_next = pwdata[1:0];
      end
      // Read clears only the flags it returned; new violations win.
      if (rd_mon) begin
         flags_next = flags_reg & ~prdata_reg[2*NUM_PARAM-1:0];
         irq_next   = 1'b0;
         armed_next = 1'b1;
      end
      flags_next = flags_next | viol;
      // A violation in the cycle of a monitor read re-raises the interrupt at once.
      if ((|viol) & armed_next & extra_reg[EXTRA_IRQ_BIT]) begin
         irq_next   = 1'b1;
         armed_next = 1'b0;
      end
      // Auto link reset pulses on a violation when enabled.
      lrst_next = (|viol) & extra_reg[EXTRA_ARST_BIT];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mon_on_reg <= LQ_MON_RST[LQ_ON_BIT];
         extra_reg  <= EXTRA_RST;
         flags_reg  <= '0;
         irq_reg    <= 1'b0;
         armed_reg  <= 1'b1;
         lrst_reg   <= 1'b0;
      end else begin
         mon_on_reg <= mon_on_next;
         extra_reg  <= extra_next;
         flags_reg  <= flags_next;
         irq_reg    <= irq_next;
         armed_reg  <= armed_next;
         lrst_reg   <= lrst_next;
      end
   end

   assign lq_irq         = irq_reg;
   assign link_reset_req = lrst_reg;

   // -----------------------------------------------------------------
   // Variance computation and readout
   // -----------------------------------------------------------------
   logic        var_en_reg;
   logic        var_en_next;
   logic        freeze_reg;
   logic        freeze_next;
   logic [1:0]  timer_reg;
   logic [1:0]  timer_next;
   logic        rdy_reg;
   logic        rdy_next;
   logic [31:0] acc_reg;
   logic [31:0] acc_next;
   logic [31:0] sum_reg;
   logic [31:0] sum_next;
   logic [23:0] cnt_reg;
   logic [23:0] cnt_next;
   logic [23:0] limit;
   logic        sum_load;
   half_t       half_reg;
   half_t       half_next;
   logic [15:0] sq;

   // Period is 2, 4, 6 or 8 units.
   assign limit = 24'((32'(timer_reg) + 32'd1) * 32'd2 * 32'(UNIT_CYC) - 32'd1);
   assign sq    = 16'(var_sample * var_sample);
   // A new sum loads at the end of a period unless the readout is frozen.
   assign sum_load = var_en_reg & (cnt_reg >= limit) & ~freeze_reg;

   always_comb begin
      var_en_next = var_en_reg;
      freeze_next = freeze_reg;
      timer_next  = timer_reg;
      rdy_next    = rdy_reg;
      acc_next    = acc_reg;
      sum_next    = sum_reg;
      cnt_next    = cnt_reg;
      half_next   = half_reg;
      if (!var_en_reg) begin
         acc_next = '0; // Computation idles while disabled.
         cnt_next = '0;
      end else if (cnt_reg >= limit) begin
         cnt_next = '0;
         acc_next = '0;
         if (!freeze_reg) begin
            sum_next = acc_reg; // Frozen sums are never replaced.
            rdy_next = 1'b1;
         end
      end else begin
         cnt_next = cnt_reg + 24'h000001;
         if (var_sample_valid) begin
            acc_next = acc_reg + 32'(sq);
         end
      end
      // Any control write restarts the computation.
      if (wr_ctrl) begin
         var_en_next = pwdata[VAR_EN_BIT];
         freeze_next = pwdata[VAR_FREEZE_BIT];
         timer_next  = pwdata[VAR_TIMER_LSB+1:VAR_TIMER_LSB];
         cnt_next    = '0;
         acc_next    = '0;
         half_next   = HALF_LOW; // Readout restarts at the low half.
      end
      if (rd_data) begin
         unique case (half_reg)
            HALF_LOW: begin
               half_next = HALF_HIGH;
            end
            HALF_HIGH: begin
               half_next   = HALF_LOW;
               rdy_next    = sum_load; // A load in the same cycle wins.
               freeze_next = 1'b0;
            end
         endcase
      end else if (access_ph & mapped) begin
         half_next = HALF_LOW; // Any other mapped access breaks the pair.
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         var_en_reg <= VAR_CTRL_RST[VAR_EN_BIT];
         freeze_reg <= VAR_CTRL_RST[VAR_FREEZE_BIT];
         timer_reg  <= VAR_CTRL_RST[VAR_TIMER_LSB+1:VAR_TIMER_LSB];
         rdy_reg    <= VAR_CTRL_RST[VAR_RDY_BIT];
         acc_reg    <= '0;
         sum_reg    <= '0;
         cnt_reg    <= '0;
         half_reg   <= HALF_LOW;
      end else begin
         var_en_reg <= var_en_next;
         freeze_reg <= freeze_next;
         timer_reg  <= timer_next;
         rdy_reg    <= rdy_next;
         acc_reg    <= acc_next;
         sum_reg    <= sum_next;
         cnt_reg    <= cnt_next;
         half_reg   <= half_next;
      end
   end

   // -----------------------------------------------------------------
   // Read data, captured in the setup cycle
   // -----------------------------------------------------------------
   always_comb begin
      prdata_next = prdata_reg;
      if (setup_ph & ~pwrite) begin
         prdata_next = '0;
         if (hit_ctrl) begin
            prdata_next[VAR_RDY_BIT]    = rdy_reg;
            prdata_next[VAR_FREEZE_BIT] = freeze_reg;
            prdata_next[VAR_TIMER_LSB+1:VAR_TIMER_LSB] = timer_reg;
            prdata_next[VAR_EN_BIT]     = var_en_reg;
         end else if (hit_data) begin
            prdata_next[15:0] = (half_reg == HALF_LOW) ? sum_reg[15:0] : sum_reg[31:16];
         end else if (hit_mon) begin
            prdata_next[LQ_ON_BIT] = mon_on_reg; // Bits 14:10 stay zero.
            prdata_next[2*NUM_PARAM-1:0] = flags_reg;
         end else if (hit_extra) begin
            prdata_next[1:0] = extra_reg;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= '0;
      end else begin
         prdata_reg <= prdata_next;
      end
   end

   assign prdata = prdata_reg;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_second_read_clears: assert property (rd_data && half_reg == HALF_HIGH
                                          |=> !freeze_reg && rdy_reg == $past(sum_load))
      else $error("Ready or freeze survived the second data read.");
   a_frozen_sum_holds: assert property (freeze_reg && !wr_ctrl |=> $stable(sum_reg))
      else $error("Sum changed while frozen.");
   a_low_half_first: assert property (setup_ph && !pwrite && hit_data && half_reg == HALF_LOW
                                      |=> prdata_reg[15:0] == $past(sum_reg[15:0]))
      else $error("First data read did not return the low half.");
   a_reserved_zero: assert property (setup_ph && !pwrite && hit_mon |=> prdata_reg[14:10] == 5'h00)
      else $error("Reserved monitor bits read nonzero.");
   a_monitor_gated: assert property (!mon_active |-> viol == '0)
      else $error("Violation flagged with monitor inactive.");
   a_flag_sticky: assert property (flags_reg[0] && !rd_mon |=> flags_reg[0])
      else $error("Warning flag dropped without a read.");
   a_irq_raise: assert property ((|viol) && armed_reg && extra_reg[EXTRA_IRQ_BIT] |=> lq_irq && !armed_reg)
      else $error("Violation did not raise the interrupt.");
   a_read_rearms: assert property (rd_mon && viol == '0 |=> !lq_irq && armed_reg)
      else $error("Monitor read did not re-arm the interrupt.");
   a_disabled_idle: assert property (!var_en_reg && !wr_ctrl |=> cnt_reg == '0 && acc_reg == '0)
      else $error("Variance counter ran while disabled.");
   a_hi_disabled: assert property (thr_value[0].hi == {PARAM_W{1'b1}} |-> !viol[1])
      else $error("Maximum high threshold flagged a violation.");

   c_two_reads: cover property (rd_data && half_reg == HALF_HIGH);
   c_irq_fire: cover property (!lq_irq ##1 lq_irq);
   c_sum_load: cover property (!rdy_reg ##1 rdy_reg);
   c_mon_clear: cover property (rd_mon && flags_reg != '0);
endmodule : lq_var_status

// File: verification/lq_var_status_tb.sv
/*
 Self-checking testbench for the link quality and variance status bank.
 Assumes the APB slave answers with zero wait states and UNIT_CYC set to 4.
*/
`timescale 1ns/1ps
module lq_var_status_tb;
   import lq_var_pkg::*;
   // -----------------------------------------------------------------
   // Signals and scoreboard
   // -----------------------------------------------------------------
   localparam logic [31:0] A_CTRL = {22'h0, IDX_VAR_CTRL, 2'h0};
   localparam logic [31:0] A_DATA = {22'h0, IDX_SUM_WIN, 2'h0};
   localparam logic [31:0] A_MON  = {22'h0, IDX_LQ_MON, 2'h0};
   localparam logic [31:0] A_EXT  = {22'h0, IDX_LQ_EXTRA, 2'h0};
   logic                         pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [31:0]                  paddr, pwdata, prdata, rdata, lfsr;
   logic                         link_100_up, var_sample_valid, lq_irq, link_reset_req;
   logic signed [7:0]            var_sample;
   param_t    [NUM_PARAM-1:0]    param_value;
   thr_pair_t [NUM_PARAM-1:0]    thr_value;
   logic [65:0]                  notes[$];
   logic [65:0]                  note;
   int                           bad_count, n_compared, cycles, pulses;
   logic [31:0]                  vsum;

   lq_var_status #(.UNIT_CYC(4)) lq_var_status_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link_100_up(link_100_up), .param_value(param_value), .thr_value(thr_value),
      .var_sample_valid(var_sample_valid), .var_sample(var_sample), .lq_irq(lq_irq),
      .link_reset_req(link_reset_req));

   // Clock generator, 5 ns period.
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   // Galois shift register for pseudo-random values.
   function automatic logic [31:0] next_rand(input logic [31:0] v);
      next_rand = {1'b0, v[31:1]} ^ (v[0] ? 32'h8020_0003 : 32'h0000_0000);
   endfunction : next_rand

   // Compares one value and counts the result.
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; a read leaves a note of {mask, pslverr and data expected}.
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      input logic [32:0] exp, input logic [32:0] msk);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      if (!wr) notes.push_back({msk, exp});
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata   = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [31:0] a, input logic [32:0] exp);
      apb(1'b0, a, 32'h0, exp, {33{1'b1}});
   endtask : rd

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0, 33'h0);
   endtask : wr

   // Pushes one parameter outside its window for a single cycle.
   task automatic viol(input int i, input bit hi);
      param_value[i] <= hi ? 8'h90 : 8'h30;
      @(posedge pclk);
      param_value[i] <= 8'h41 + 8'(lfsr % 32'h3F);
      lfsr = next_rand(lfsr);
      repeat (3) @(posedge pclk);
   endtask : viol

   task automatic print_verdict;
      $display("compared=%0d mismatches=%0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   // Watches completed reads and compares them against the oldest note.
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         note = notes.pop_front();
         if (note[65:33] != 33'h0) chk({pslverr, prdata} & note[65:33], note[32:0]);
      end
   end

   // Counts link reset pulses and bounds the run.
   always @(posedge pclk) begin
      if (link_reset_req === 1'b1) pulses++;
      cycles++;
      if (cycles > 20000) begin
         bad_count++;
         print_verdict();
      end
   end

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, presetn, link_100_up, var_sample_valid} = 6'h00;
      paddr = 32'h0; pwdata = 32'h0; var_sample = 8'sh00; lfsr = 32'd76060;
      bad_count = 0; n_compared = 0; cycles = 0; pulses = 0; vsum = 32'h0;
      for (int i = 0; i < NUM_PARAM; i++) begin
         param_value[i] = 8'h60;
         thr_value[i] = '{hi: 8'hFF, lo: 8'h00};
      end
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      var_sample_valid <= 1'b1;
      var_sample <= 8'sh7F;
      repeat (40) @(posedge pclk);
      var_sample_valid <= 1'b0;
      rd(A_CTRL, 33'h0);
      rd(A_DATA, 33'h0);
      rd(A_MON, 33'h0);
      rd(A_EXT, 33'h0);
      rd(32'h0000_007C, 33'h1_0000_0000);
      $display("test reset values done");
      wr(A_MON, 32'h0000_FFFF);
      link_100_up <= 1'b1;
      for (int i = 0; i < NUM_PARAM; i++) param_value[i] <= 8'hFF;
      repeat (3) @(posedge pclk);
      rd(A_MON, 33'h8000);
      for (int i = 0; i < NUM_PARAM; i++) param_value[i] <= 8'h00;
      repeat (3) @(posedge pclk);
      rd(A_MON, 33'h8000);
      $display("test disabled thresholds done");
      for (int i = 0; i < NUM_PARAM; i++) begin
         param_value[i] <= 8'h60;
         thr_value[i] <= '{hi: 8'h80, lo: 8'h40};
      end
      @(posedge pclk);
      for (int i = 0; i < NUM_PARAM; i++) begin
         for (int h = 0; h < 2; h++) begin
            viol(i, h[0]);
            rd(A_MON, 33'h8000 | (33'h1 << (2 * i + h)));
            rd(A_MON, 33'h8000);
         end
      end
      $display("test warning flags done");
      link_100_up <= 1'b0;
      viol(2, 1'b1);
      rd(A_MON, 33'h8000);
      link_100_up <= 1'b1;
      wr(A_MON, 32'h0);
      viol(3, 1'b1);
      rd(A_MON, 33'h0);
      wr(A_MON, 32'h8000);
      $display("test monitor qualify done");
      wr(A_EXT, 32'h1);
      pulses = 0;
      viol(0, 1'b1);
      chk({32'h0, lq_irq}, 33'h1);
      rd(A_MON, 33'h8002);
      repeat (2) @(posedge pclk);
      chk({32'h0, lq_irq}, 33'h0);
      viol(0, 1'b0);
      chk({32'h0, lq_irq}, 33'h1);
      rd(A_MON, 33'h8001);
      chk(33'(pulses), 33'h0);
      wr(A_EXT, 32'h3);
      viol(1, 1'b1);
      chk({32'h0, pulses > 0}, 33'h1);
      rd(A_MON, 33'h8008);
      wr(A_EXT, 32'h0);
      viol(3, 1'b0);
      chk({32'h0, lq_irq}, 33'h0);
      rd(A_MON, 33'h8040);
      $display("test interrupt done");
      wr(A_CTRL, 32'h7);
      for (int k = 0; k < 8; k++) begin
         var_sample_valid <= 1'b1;
         var_sample <= (k < 4) ? -8'sd128 : $signed(lfsr[7:0]);
         vsum += (k < 4) ? 32'd16384 : 32'($signed(lfsr[7:0]) * $signed(lfsr[7:0]));
         lfsr = next_rand(lfsr);
         @(posedge pclk);
      end
      var_sample_valid <= 1'b0;
      rdata = 32'h0;
      for (int k = 0; k < 100 && rdata[VAR_RDY_BIT] !== 1'b1; k++) apb(1'b0, A_CTRL, 32'h0, 33'h0, 33'h0);
      chk({1'b0, rdata}, 33'h8007);
      wr(A_CTRL, 32'hF);
      rd(A_DATA, {17'h0, vsum[15:0]});
      rd(A_DATA, {17'h0, vsum[31:16]});
      rd(A_CTRL, 33'h7);
      $display("test variance readout done");
      repeat (4) @(posedge pclk);
      print_verdict();
   end
endmodule : lq_var_status_tb
